// ==== usbie_regs.svh ====
/*
 * register offsets, field positions, reset values and widths for the
 * usb event mask and descriptor-table base slice.
 * assumes a 12-bit byte address on the apb side, one word per register.
 */
`ifndef USBIE_REGS_SVH
`define USBIE_REGS_SVH

// byte offsets of the four words
`define USBIE_MASK_OFS 12'h000
`define USBIE_BASE_MID_OFS 12'h004
`define USBIE_BASE_HIGH_OFS 12'h008
`define USBIE_STATUS_OFS 12'h00C

// event and enable bit positions, shared by mask and status
`define USBIE_BIT_STALL 7
`define USBIE_BIT_ATTACH 6
`define USBIE_BIT_RESUME 5
`define USBIE_BIT_IDLE 4
`define USBIE_BIT_TOKEN 3
`define USBIE_BIT_FRAME 2
`define USBIE_BIT_ERROR 1
`define USBIE_BIT_RST_DET 0

// reset values
`define USBIE_MASK_RST 8'h00
`define USBIE_BASE_RST 8'h00
`define USBIE_STATUS_RST 8'h00

// descriptor table alignment and field widths
`define USBIE_ALIGN_BITS 9
`define USBIE_LOW_PAGE_W 7
`define USBIE_ADDR_W 12

`endif

// ==== usbie_pkg.sv ====
/*
 * types for the usb event mask and descriptor-table base slice.
 * assumes nothing beyond the register header.
 */
package usbie_pkg;

    // apb answer phase, one-hot
    typedef enum logic [1:0] {
        USBIE_IDLE = 2'b01,
        USBIE_ANSWER = 2'b10
    } usbie_phase_t;

    typedef logic [7:0] usbie_byte_t;

endpackage

// ==== usbie_top.sv ====
/*
 * usb interrupt-enable mask, sticky event status and buffer descriptor
 * table base pages behind an apb slave, with one level interrupt.
 * assumes event pulses and the low page bits come from logic on i_clk,
 * and that the apb master keeps its request steady until pready.
 */
// Design decisions made here: the APB register port and the address map.
// Behaviour
// - mask bit 7 passes or blocks the stall handshake event.
// - mask bit 6 passes or blocks the attach event.
// - mask bit 5 passes or blocks the resume event.
// - mask bit 4 passes or blocks the bus idle event.
// - mask bit 3 passes or blocks the token done flag.
// - mask bit 2 passes or blocks the frame start flag.
// - mask bit 1 passes or blocks usb error events.
// - device role: mask bit 0 enables the bus reset flag.
// - host role: mask bit 0 enables the detach flag instead.
// - error interrupts reach the module interrupt only with mask bit 1 set.
// - bits 31 to 8 of mask and base pages ignore writes, read zero.
// - middle page holds base address bits 23 to 16.
// - high page holds base address bits 31 to 24.
// - descriptor table base is 512-byte aligned, low nine bits zero.
`timescale 1ns/1ns

`include "usbie_regs.svh"

module usbie_top
    import usbie_pkg::*;
(
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`USBIE_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // usb event pulses, bits 7 to 1 of the status layout
    input wire logic [7:1] i_usb_evt,
    input wire logic i_bus_reset_evt,
    input wire logic i_detach_evt,
    input wire logic i_host_mode,
    // low page of the descriptor base, bits 15 to 9
    input wire logic [`USBIE_LOW_PAGE_W-1:0] i_desc_base_bits_15_9,
    // results
    output logic o_irq,
    output logic [31:0] o_desc_base
);

    // word decode, used by the read path and the write path
    function automatic logic addr_hit(
        input logic [`USBIE_ADDR_W-1:0] addr,
        input logic [`USBIE_ADDR_W-1:0] ofs
    );
        addr_hit = (addr == ofs);
    endfunction

    usbie_phase_t state_ff;
    usbie_byte_t usb_event_irq_mask_ff;
    usbie_byte_t usb_desc_table_base_mid_ff;
    usbie_byte_t usb_desc_table_base_high_ff;
    usbie_byte_t status_ff;
    usbie_byte_t nxt_status;
    usbie_byte_t nxt_mask;
    usbie_byte_t evt_set;
    usbie_byte_t rd_clear;
    usbie_byte_t rd_byte;
    logic rd_status_ff;
    logic prdata_zero_ok;
    logic mapped;
    logic setup;
    logic done;
    logic wr_en;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic [31:0] desc_base_ff;

    // bus phases; done marks the edge where the master sees pready
    assign setup = i_psel & ~i_penable & (state_ff == USBIE_IDLE);
    assign done = i_psel & i_penable & (state_ff == USBIE_ANSWER);
    assign wr_en = done & i_pwrite & i_pstrb[0];

    // register decode and read mux; upper bytes always zero
    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        if (addr_hit(i_paddr, `USBIE_MASK_OFS)) begin
            rd_byte = usb_event_irq_mask_ff;
        end else if (addr_hit(i_paddr, `USBIE_BASE_MID_OFS)) begin
            rd_byte = usb_desc_table_base_mid_ff;
        end else if (addr_hit(i_paddr, `USBIE_BASE_HIGH_OFS)) begin
            rd_byte = usb_desc_table_base_high_ff;
        end else if (addr_hit(i_paddr, `USBIE_STATUS_OFS)) begin
            rd_byte = status_ff;
        end else begin
            mapped = 1'b0;
        end
    end

    // apb answer: one wait-free access phase after each setup
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff <= USBIE_IDLE;
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
            rd_status_ff <= 1'b0;
        end else if (i_ce) begin
            unique case (state_ff)
                USBIE_IDLE: begin
                    if (setup) begin
                        state_ff <= USBIE_ANSWER;
                        pready_ff <= 1'b1;
                        prdata_ff <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                        pslverr_ff <= ~mapped;
                        rd_status_ff <= ~i_pwrite & addr_hit(i_paddr, `USBIE_STATUS_OFS);
                    end
                end
                USBIE_ANSWER: begin
                    if (done) begin
                        state_ff <= USBIE_IDLE;
                        pready_ff <= 1'b0;
                        prdata_ff <= 32'h0000_0000;
                        pslverr_ff <= 1'b0;
                        rd_status_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    // next mask; only the low byte is stored, the rest is dropped
    always_comb begin
        nxt_mask = usb_event_irq_mask_ff;
        if (wr_en && addr_hit(i_paddr, `USBIE_MASK_OFS)) begin
            nxt_mask = i_pwdata[7:0];
        end
    end

    // mask register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            usb_event_irq_mask_ff <= `USBIE_MASK_RST;
        end else if (i_ce) begin
            usb_event_irq_mask_ff <= nxt_mask;
        end
    end

    // descriptor base pages
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            usb_desc_table_base_mid_ff <= `USBIE_BASE_RST;
            usb_desc_table_base_high_ff <= `USBIE_BASE_RST;
        end else if (i_ce && wr_en) begin
            if (addr_hit(i_paddr, `USBIE_BASE_MID_OFS)) begin
                usb_desc_table_base_mid_ff <= i_pwdata[7:0];
            end
            if (addr_hit(i_paddr, `USBIE_BASE_HIGH_OFS)) begin
                usb_desc_table_base_high_ff <= i_pwdata[7:0];
            end
        end
    end

    // bit 0 changes meaning with the role
    always_comb begin
        evt_set = {i_usb_evt, 1'b0};
        if (i_host_mode) begin
            evt_set[`USBIE_BIT_RST_DET] = i_detach_evt;
        end else begin
            evt_set[`USBIE_BIT_RST_DET] = i_bus_reset_evt;
        end
    end

    // read-clear drops only what the reader saw, so a later event survives
    assign rd_clear = (done && rd_status_ff) ? prdata_ff[7:0] : 8'h00;
    // set wins over the clear in the same cycle
    assign nxt_status = (status_ff & ~rd_clear) | evt_set;

    // sticky status; events during i_ce low are not seen
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            status_ff <= `USBIE_STATUS_RST;
        end else if (i_ce) begin
            status_ff <= nxt_status;
        end
    end

    // irq from next values so it tracks status and mask without lag
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_ff <= 1'b0;
        end else if (i_ce) begin
            // per-bit gate
            irq_ff <= |(nxt_status & nxt_mask);
        end
    end

    // full base address; one cycle behind the page registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            desc_base_ff <= 32'h0000_0000;
        end else if (i_ce) begin
            desc_base_ff <= {usb_desc_table_base_high_ff, usb_desc_table_base_mid_ff,
                             i_desc_base_bits_15_9, {`USBIE_ALIGN_BITS{1'b0}}};
        end
    end

    // outputs straight from flops
    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_irq = irq_ff;
    assign o_desc_base = desc_base_ff;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    assign prdata_zero_ok = (prdata_ff[31:8] == 24'h00_0000);

    a_stall_gate: assert property (
        status_ff[7] && usb_event_irq_mask_ff[7] |-> o_irq)
        else $error("stall event not passed by mask");
    a_stall_block: assert property (
        status_ff == 8'h80 && !usb_event_irq_mask_ff[7] |-> !o_irq)
        else $error("stall event not blocked");
    a_attach_gate: assert property (
        (status_ff == 8'h40) |-> (o_irq == usb_event_irq_mask_ff[6]))
        else $error("attach gate wrong");
    a_resume_gate: assert property (
        (status_ff == 8'h20) |-> (o_irq == usb_event_irq_mask_ff[5]))
        else $error("resume gate wrong");
    a_idle_gate: assert property (
        (status_ff == 8'h10) |-> (o_irq == usb_event_irq_mask_ff[4]))
        else $error("idle gate wrong");
    a_token_gate: assert property (
        (status_ff == 8'h08) |-> (o_irq == usb_event_irq_mask_ff[3]))
        else $error("token done gate wrong");
    a_frame_gate: assert property (
        (status_ff == 8'h04) |-> (o_irq == usb_event_irq_mask_ff[2]))
        else $error("frame start gate wrong");
    a_error_gate: assert property (
        (status_ff == 8'h02) |-> (o_irq == usb_event_irq_mask_ff[1]))
        else $error("error gate wrong");
    a_reset_flag: assert property (
        i_ce && !i_host_mode && i_bus_reset_evt |=> status_ff[0])
        else $error("bus reset flag not set");
    a_detach_flag: assert property (
        i_ce && i_host_mode && i_detach_evt |=> status_ff[0])
        else $error("detach flag not set");
    a_error_mask: assert property (
        status_ff[1] && !usb_event_irq_mask_ff[1] && !o_irq |-> ##1 !(o_irq && $stable(status_ff)
            && $stable(usb_event_irq_mask_ff)))
        else $error("error irq without enable");
    a_upper_zero: assert property (
        prdata_zero_ok && (done || !o_pready || prdata_ff == 32'h0000_0000))
        else $error("upper read bits not zero");
    a_mid_page: assert property (
        $past(i_ce) |-> o_desc_base[23:16] == $past(usb_desc_table_base_mid_ff))
        else $error("base bits 23:16 wrong");
    a_high_page: assert property (
        $past(i_ce) |-> o_desc_base[31:24] == $past(usb_desc_table_base_high_ff))
        else $error("base bits 31:24 wrong");
    a_base_align: assert property (
        o_desc_base[8:0] == 9'h000)
        else $error("base not 512-byte aligned");
    a_irq_level: assert property (
        ##1 (o_irq == |(status_ff & usb_event_irq_mask_ff)))
        else $error("irq level mismatch");
    a_mask_write: assert property (
        i_ce && wr_en && addr_hit(i_paddr, `USBIE_MASK_OFS)
            |=> usb_event_irq_mask_ff == $past(i_pwdata[7:0]))
        else $error("mask write lost");

    // each event line sets its own sticky bit at the sampling edge
    a_stall_flag: assert property (
        i_ce && i_usb_evt[7] |=> status_ff[7])
        else $error("stall event not latched");
    a_attach_flag: assert property (
        i_ce && i_usb_evt[6] |=> status_ff[6])
        else $error("attach event not latched");
    a_resume_flag: assert property (
        i_ce && i_usb_evt[5] |=> status_ff[5])
        else $error("resume event not latched");
    a_idle_flag: assert property (
        i_ce && i_usb_evt[4] |=> status_ff[4])
        else $error("idle event not latched");
    a_token_flag: assert property (
        i_ce && i_usb_evt[3] |=> status_ff[3])
        else $error("token done not latched");
    a_frame_flag: assert property (
        i_ce && i_usb_evt[2] |=> status_ff[2])
        else $error("frame start not latched");
    a_error_flag: assert property (
        i_ce && i_usb_evt[1] |=> status_ff[1])
        else $error("error event not latched");

    // bit 0 follows the role: the other source must leave it clear
    a_detach_ignored: assert property (
        i_ce && !i_host_mode && !i_bus_reset_evt && !status_ff[0] |=> !status_ff[0])
        else $error("detach set bit 0 in device role");
    a_reset_ignored: assert property (
        i_ce && i_host_mode && !i_detach_evt && !status_ff[0] |=> !status_ff[0])
        else $error("bus reset set bit 0 in host role");
    a_bit0_dev_gate: assert property (
        !i_host_mode && status_ff == 8'h01 |-> o_irq == usb_event_irq_mask_ff[0])
        else $error("bus reset gate wrong");
    a_bit0_host_gate: assert property (
        i_host_mode && status_ff == 8'h01 |-> o_irq == usb_event_irq_mask_ff[0])
        else $error("detach gate wrong");

    // status only changes through events and status reads
    a_status_hold: assert property (
        i_ce && !(done && rd_status_ff) |=> ($past(status_ff) & ~status_ff) == 8'h00)
        else $error("status bit lost without a read");
    a_status_source: assert property (
        i_ce |=> (status_ff & ~$past(status_ff | evt_set)) == 8'h00)
        else $error("status bit set without an event");
    a_read_clear: assert property (
        i_ce && done && rd_status_ff |=> (status_ff & $past(prdata_ff[7:0] & ~evt_set)) == 8'h00)
        else $error("status read did not clear");
    a_irq_quiet: assert property (
        status_ff == 8'h00 |-> !o_irq)
        else $error("irq with empty status");
    a_ce_freeze: assert property (
        !i_ce |=> $stable(status_ff) && $stable(usb_event_irq_mask_ff) && $stable(o_irq))
        else $error("state moved with clock enable low");

    // apb answer timing and side results
    a_ready_setup: assert property (
        i_ce && setup |=> o_pready)
        else $error("no answer after setup");
    a_ready_drop: assert property (
        i_ce && done |=> !o_pready)
        else $error("ready held after access");
    a_idle_quiet: assert property (
        !o_pready |-> o_prdata == 32'h0000_0000 && !o_pslverr)
        else $error("read data outside access cycle");
    a_write_rdata: assert property (
        i_ce && setup && i_pwrite |=> o_prdata == 32'h0000_0000)
        else $error("read data on a write");
    a_err_unmapped: assert property (
        i_ce && setup && !mapped |=> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (
        i_ce && setup && mapped |=> !o_pslverr)
        else $error("mapped access refused");

    // stored bytes change only on their own writes
    a_mid_write: assert property (
        i_ce && wr_en && addr_hit(i_paddr, `USBIE_BASE_MID_OFS)
            |=> usb_desc_table_base_mid_ff == $past(i_pwdata[7:0]))
        else $error("base mid write lost");
    a_high_write: assert property (
        i_ce && wr_en && addr_hit(i_paddr, `USBIE_BASE_HIGH_OFS)
            |=> usb_desc_table_base_high_ff == $past(i_pwdata[7:0]))
        else $error("base high write lost");
    a_page_hold: assert property (
        !wr_en |=> $stable(usb_desc_table_base_mid_ff) && $stable(usb_desc_table_base_high_ff))
        else $error("base page moved without a write");
    a_mask_hold: assert property (
        !wr_en |=> $stable(usb_event_irq_mask_ff))
        else $error("mask moved without a write");
    a_low_page: assert property (
        $past(i_ce) && $past(i_rst_n) |-> o_desc_base[15:9] == $past(i_desc_base_bits_15_9))
        else $error("base bits 15:9 wrong");

    c_irq_rise: cover property (!o_irq ##1 o_irq);
    c_status_read: cover property (done && rd_status_ff && prdata_ff[7:0] != 8'h00);
    c_host_detach: cover property (i_ce && i_host_mode && i_detach_evt);
    c_set_clear: cover property (done && rd_status_ff && |(evt_set & prdata_ff[7:0]));

endmodule

// ==== usbie_usb_peer.sv ====
/*
 * behavioural far side of the usb link: turns a request from the bench
 * into one event pulse on the matching line, one cycle long.
 * assumes the bench raises i_fire for one cycle, just after a rising edge.
 */
`timescale 1ns/1ns

module usbie_usb_peer (
    // clock
    input wire logic i_clk,
    // request from the bench
    input wire logic i_fire,
    input wire logic [2:0] i_idx,
    input wire logic i_alt,
    // event pulses towards the slice
    output logic [7:1] o_usb_evt,
    output logic o_bus_reset_evt,
    output logic o_detach_evt
);
    // registered pulse, so lines change only just after an edge
    always @(posedge i_clk) begin
        o_usb_evt <= 7'h00;
        o_bus_reset_evt <= 1'h0;
        o_detach_evt <= 1'h0;
        if (i_fire && i_idx == 3'h0) begin
            o_detach_evt <= i_alt; // bit 0 shares two sources
            o_bus_reset_evt <= ~i_alt;
        end else if (i_fire) begin
            o_usb_evt <= 7'h01 << (i_idx - 3'h1);
        end
    end
endmodule

// ==== tb_usbie_top.sv ====
/*
 * self-checking bench for the usb event mask and descriptor base slice.
 * assumes the register header offsets and zero wait state apb answers.
 */
`timescale 1ns/1ns

`include "usbie_regs.svh"

module tb_usbie_top;
    typedef struct {
        logic [7:0] mask;
        logic [2:0] idx;
        logic host;
        logic alt;
        logic set;
        logic irq;
    } usbie_row_t;

    logic i_clk = 1'h0;
    logic i_rst_n = 1'h0;
    logic i_psel = 1'h0;
    logic i_penable = 1'h0;
    logic i_pwrite = 1'h0;
    logic i_host_mode = 1'h0;
    logic ce = 1'h1;
    logic fire = 1'h0;
    logic alt = 1'h0;
    logic [2:0] idx = 3'h0;
    logic [6:0] low_page = 7'h00;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic [31:0] o_desc_base;
    logic o_pready;
    logic o_pslverr;
    logic o_irq;
    logic bus_rst;
    logic detach;
    logic [7:1] usb_evt;
    int n_mismatch = 0;
    int tests_run = 0;
    // inputs, expected status set and expected interrupt level
    usbie_row_t rows [18] = '{
        '{8'h80, 3'h7, 1'h0, 1'h0, 1'h1, 1'h1}, '{8'h7F, 3'h7, 1'h0, 1'h0, 1'h1, 1'h0},
        '{8'h40, 3'h6, 1'h0, 1'h0, 1'h1, 1'h1}, '{8'hBF, 3'h6, 1'h0, 1'h0, 1'h1, 1'h0},
        '{8'h20, 3'h5, 1'h0, 1'h0, 1'h1, 1'h1}, '{8'hDF, 3'h5, 1'h0, 1'h0, 1'h1, 1'h0},
        '{8'h10, 3'h4, 1'h0, 1'h0, 1'h1, 1'h1}, '{8'hEF, 3'h4, 1'h0, 1'h0, 1'h1, 1'h0},
        '{8'h08, 3'h3, 1'h0, 1'h0, 1'h1, 1'h1}, '{8'hF7, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0},
        '{8'h04, 3'h2, 1'h0, 1'h0, 1'h1, 1'h1}, '{8'hFB, 3'h2, 1'h0, 1'h0, 1'h1, 1'h0},
        '{8'h02, 3'h1, 1'h0, 1'h0, 1'h1, 1'h1}, '{8'hFD, 3'h1, 1'h0, 1'h0, 1'h1, 1'h0},
        '{8'h01, 3'h0, 1'h0, 1'h0, 1'h1, 1'h1}, '{8'hFE, 3'h0, 1'h1, 1'h1, 1'h1, 1'h0},
        '{8'h01, 3'h0, 1'h1, 1'h1, 1'h1, 1'h1}, '{8'hFF, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0}
    };

    // 50 ns period
    always #25 i_clk = ~i_clk;

    usbie_usb_peer u_peer (
        .i_clk(i_clk), .i_fire(fire), .i_idx(idx), .i_alt(alt),
        .o_usb_evt(usb_evt), .o_bus_reset_evt(bus_rst), .o_detach_evt(detach)
    );

    // byte strobes tied on: partial writes are not exercised here
    usbie_top u_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(4'hF),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_usb_evt(usb_evt), .i_bus_reset_evt(bus_rst), .i_detach_evt(detach),
        .i_host_mode(i_host_mode), .i_desc_base_bits_15_9(low_page),
        .o_irq(o_irq), .o_desc_base(o_desc_base)
    );

    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask

    // one apb transfer; an idle cycle first so no signal is driven twice
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'h1);
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask

    task rd(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0, r, e);
        check(nm, exp, r);
        check("pslverr", {31'h0, xe}, {31'h0, e});
    endtask

    // event pulse through the peer, then time for status and irq to land
    task pulse(input logic [2:0] k, input logic a);
        @(posedge i_clk);
        fire <= 1'h1;
        idx <= k;
        alt <= a;
        @(posedge i_clk);
        fire <= 1'h0;
        repeat (2) @(posedge i_clk);
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog: about sixteen times the expected run
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'h1;
        rd("mask", `USBIE_MASK_OFS, 32'h0, 1'h0);
        rd("mid", `USBIE_BASE_MID_OFS, 32'h0, 1'h0);
        rd("high", `USBIE_BASE_HIGH_OFS, 32'h0, 1'h0);
        rd("unmapped", 12'h010, 32'h0, 1'h1);
        // upper bits written nonzero must read back zero
        low_page <= 7'h55;
        wr(`USBIE_MASK_OFS, 32'hFFFFFF5A);
        wr(`USBIE_BASE_MID_OFS, 32'h1234563C);
        wr(`USBIE_BASE_HIGH_OFS, 32'hABCDEFA5);
        rd("mask", `USBIE_MASK_OFS, 32'h5A, 1'h0);
        rd("mid", `USBIE_BASE_MID_OFS, 32'h3C, 1'h0);
        rd("high", `USBIE_BASE_HIGH_OFS, 32'hA5, 1'h0);
        check("desc base", 32'hA53CAA00, o_desc_base);
        // each enable bit passes and blocks its own event
        foreach (rows[i]) begin
            i_host_mode <= rows[i].host;
            wr(`USBIE_MASK_OFS, {24'h0, rows[i].mask});
            pulse(rows[i].idx, rows[i].alt);
            check("irq", {31'h0, rows[i].irq}, {31'h0, o_irq});
            rd("status", `USBIE_STATUS_OFS, rows[i].set ? 32'h1 << rows[i].idx : 32'h0, 1'h0);
            @(posedge i_clk);
            check("irq clear", 32'h0, {31'h0, o_irq});
        end
        // events while the clock enable is low are lost
        ce <= 1'h0;
        pulse(3'h2, 1'h0);
        ce <= 1'h1;
        check("irq ce", 32'h0, {31'h0, o_irq});
        rd("status ce", `USBIE_STATUS_OFS, 32'h0, 1'h0);
        // reset in mid-run with an interrupt pending
        wr(`USBIE_MASK_OFS, 32'h000000FF);
        pulse(3'h3, 1'h0);
        check("irq", 32'h1, {31'h0, o_irq});
        i_rst_n <= 1'h0;
        repeat (2) @(posedge i_clk);
        check("irq rst", 32'h0, {31'h0, o_irq});
        check("desc rst", 32'h0, o_desc_base);
        i_rst_n <= 1'h1;
        rd("mask", `USBIE_MASK_OFS, 32'h0, 1'h0);
        rd("status", `USBIE_STATUS_OFS, 32'h0, 1'h0);
        report_and_stop;
    end
endmodule
